/* File: test/hcvr_host_model.sv */
// Behavioural audio link host: frames commands and collects answers
`default_nettype none

module hcvr_host_model (
  output logic      bit_clk,
  output logic      sync,
  output logic      sdo,
  output logic      link_rst_n,
  input  wire logic sdi_o,
  input  wire logic sdi_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bit_clk = 1'b0;
    sync = 1'b0;
    sdo = 1'b0;
    link_rst_n = 1'b0;
  end

  // Sample late in the period: codec output lags the rise by its syncs
  task automatic pulse(output logic oe_n, output logic d);
    #4 bit_clk = 1'b1;
    #32 bit_clk = 1'b0;
    #28;
    oe_n = sdi_oe_n;
    d = sdi_o;
  endtask : pulse

  // Clock stands low between frames
  task automatic frame(input logic [31:0] cmd, output logic [32:0] got);
    logic        oe_n;
    logic        d;
    logic        drv;
    logic        rel;
    logic [31:0] rsp;
    sync = 1'b1;
    pulse(oe_n, d);
    drv = !oe_n && d;
    rel = oe_n;
    sync = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdo = cmd[i];
      pulse(oe_n, d);
      rsp[i] = d;
      drv &= !oe_n;
      rel &= oe_n;
    end
    // Released line must not look like the last bit
    sdo = !cmd[0];
    pulse(oe_n, d);
    drv &= oe_n;
    rel &= oe_n;
    if (drv) got = {1'b1, rsp};
    else if (rel) got = 33'h000000000;
    else got = 33'h0FFFFFFFF;
  endtask : frame

  task automatic link_reset();
    link_rst_n = 1'b0;
    #256 link_rst_n = 1'b1;
    #256;
  endtask : link_reset
endmodule : hcvr_host_model

`default_nettype wire

/* File: test/hcvr_verb_responder_tb.sv */
// Self-checking bench for the codec verb responder
`default_nettype none

module hcvr_verb_responder_tb import hcvr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CC  = 5;
  localparam bit LIN = 1'b1;
  localparam bit KD  = 1'b1;
  localparam int KS  = 9;

  logic        ref_clk;
  logic        rstn;
  logic        bit_clk, sync, sdo, link_rst_n, sdi_o, sdi_oe_n;
  int          bad_count;
  int          check_count;
  logic [15:0] coef_m;
  logic [32:0] prev;
  logic [32:0] got;
  logic [31:0] r;
  logic [7:0]  pids [5] = '{8'h0F, 8'h10, 8'h11, 8'h13, 8'h12};
  logic [11:0] vtab [3] = '{12'h701, 12'h703, 12'hF03};

  hcvr_verb_responder #(.COEF_COUNT(CC), .LINEAR_PROC(LIN),
    .KNOB_DELTA(KD), .KNOB_STEPS(KS)) dut (.REF_CLK(ref_clk),
    .RSTN(rstn), .BIT_CLK(bit_clk), .SYNC(sync), .SDO(sdo),
    .LINK_RST_N(link_rst_n), .SDI_O(sdi_o), .SDI_OE_N(sdi_oe_n));

  hcvr_host_model host (.bit_clk(bit_clk), .sync(sync), .sdo(sdo),
    .link_rst_n(link_rst_n), .sdi_o(sdi_o), .sdi_oe_n(sdi_oe_n));

  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // Entry 0 in the low byte
  function automatic logic [95:0] lst(input logic [7:0] n);
    case (n)
      8'h07: lst = 96'h24;
      8'h08: lst = 96'h23;
      8'h09: lst = 96'h22;
      8'h0A: lst = 96'h1F;
      8'h0B: lst = 96'h1D1C1B1A1918;
      8'h0C, 8'h0E: lst = 96'h0B02;
      8'h0D: lst = 96'h0B03;
      8'h14, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h1B: lst = 96'h0D0C;
      8'h16: lst = 96'h0E;
      8'h11, 8'h1E: lst = 96'h06;
      8'h22, 8'h23, 8'h24: lst = 96'h0B15141D1C1B1A1918;
      default: lst = 96'h0;
    endcase
  endfunction : lst

  task automatic model(input logic [31:0] c, output logic [32:0] e);
    logic [7:0]  n;
    logic [95:0] l;
    int          cnt;
    n = c[27:20];
    l = lst(n);
    cnt = 0;
    e = {1'b1, 32'h00000000};
    for (int i = 0; i < 12; i++) cnt += int'(l[8*i +: 8] != 8'h00);
    if (c[31:28] != 4'h0) e = 33'h000000000;
    else if (c[19:16] >= 4'h2 && c[19:16] <= 4'hD) begin
      if (c[19:16] == 4'h5 && n == 8'h20) coef_m = c[15:0];
      if (c[19:16] == 4'hD && n == 8'h20) e[15:0] = coef_m;
    end else if (c[19:8] == 12'hF00) begin
      case (c[7:0])
        8'h0E: e[7:0] = 8'(cnt);
        8'h0F: e[31:0] = 32'hC000000F;
        8'h10: e[31:0] = {16'h0000, 8'(CC), 7'h00, LIN};
        8'h11: e[31:0] = 32'h40000004;
        8'h13: if (n == 8'h21) e[7:0] = {KD, 7'(KS)};
        default: ;
      endcase
    end else if (c[19:8] == 12'hF02 && c[7:2] < 6'h03)
      e[31:0] = l[32*int'(c[7:2]) +: 32];
  endtask : model

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Each frame returns the answer to the previous command
  task automatic send(input logic [31:0] c);
    logic [32:0] e;
    host.frame(c, got);
    check(got, prev);
    model(c, e);
    prev = e;
  endtask : send

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    bad_count = 0;
    check_count = 0;
    coef_m = 16'h0000;
    prev = 33'h000000000;
    void'($urandom(37));
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    host.link_reset();
    for (int n = 0; n < 40; n++) begin
      send({4'h0, 8'(n), 12'hF00, 8'h0E});
      send({4'h0, 8'(n), 12'hF00, pids[n % 5]});
    end
    $display("test params done");
    // Nodes without a list are probed too, for their zero answer
    for (int n = 0; n < 40; n++)
      for (int k = 0; k < 4; k++) begin
        r = $urandom;
        send({4'h0, 8'(n), 12'hF02, 6'(k), r[1:0]});
      end
    $display("test lists done");
    for (int k = 0; k < 6; k++) begin
      r = $urandom;
      send({4'h0, r[27:20], vtab[k % 3], r[7:0]});
    end
    $display("test zero verbs done");
    r = $urandom;
    send({12'h020, 4'h5, r[15:0]});
    send({12'h020, 4'hD, 16'h0000});
    send({12'h007, 4'h5, ~r[15:0]});
    send({12'h007, 4'hD, 16'h0000});
    send({12'h120, 4'h5, 16'h1234});
    send({12'h020, 4'hD, 16'h0000});
    send({12'h020, 4'h3, r[31:16]});
    send({12'h020, 12'hE00, r[7:0]});
    send({12'h020, 12'h1FF, r[7:0]});
    $display("test index done");
    send({12'h020, 4'h5, r[31:16]});
    send({12'h020, 4'hD, 16'h0000});
    host.link_reset();
    coef_m = 16'h0000;
    prev = 33'h000000000;
    send({12'h020, 4'hD, 16'h0000});
    send({12'h100, 12'hF00, 8'h0F});
    host.frame(32'h0000_0000, got);
    check(got, prev);
    $display("test link reset done");
    end_of_test();
  end
endmodule : hcvr_verb_responder_tb

`default_nettype wire

/* File: verilog/hcvr_link_port.sv */
// Link pin sampling, command capture and response shifting
`default_nettype none

module hcvr_link_port
  import hcvr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              bclk_pin,
  input  wire logic              sync_pin,
  input  wire logic              sdo_pin,
  input  wire logic              lrst_n_pin,
  input  wire logic              rsp_valid,
  input  wire logic [CMD_W-1:0]  rsp_word,
  output logic                   cmd_valid,
  output logic      [CMD_W-1:0]  cmd_word,
  output logic                   link_rst,
  output logic                   sdi_o,
  output logic                   sdi_oe_n
);
  logic [3:0]       meta_r;
  logic [3:0]       pin_r;
  logic             bclk_d_r;
  logic             rise;
  logic [CMD_W-1:0] rx_sh_r, rx_sh_nxt;
  logic [5:0]       rx_cnt_r, rx_cnt_nxt;
  logic             rx_on_r, rx_on_nxt;
  logic             vld_r, vld_nxt;
  logic [CMD_W-1:0] tx_sh_r, tx_sh_nxt;
  logic [5:0]       tx_cnt_r, tx_cnt_nxt;
  logic             pend_r, pend_nxt;
  logic             sdi_r, sdi_nxt;
  logic             oe_n_r, oe_n_nxt;
  logic             load;

  // Pins are asynchronous to the reference clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r   <= 4'h0;
      pin_r    <= 4'h0;
      bclk_d_r <= 1'b0;
    end else begin
      meta_r   <= {lrst_n_pin, sdo_pin, sync_pin, bclk_pin};
      pin_r    <= meta_r;
      bclk_d_r <= pin_r[0];
    end
  end

  assign rise     = pin_r[0] & ~bclk_d_r;
  assign link_rst = ~pin_r[3];
  assign load     = rise & pin_r[1] & pend_r;

  always_comb begin
    rx_sh_nxt  = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_on_nxt  = rx_on_r;
    vld_nxt    = 1'b0;
    tx_sh_nxt  = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    sdi_nxt    = sdi_r;
    oe_n_nxt   = oe_n_r;
    // New answer wins over the consuming load
    pend_nxt   = rsp_valid | (pend_r & ~load);
    if (link_rst) begin
      rx_on_nxt  = 1'b0;
      rx_cnt_nxt = 6'h00;
      tx_cnt_nxt = 6'h00;
      pend_nxt   = 1'b0;
      sdi_nxt    = 1'b0;
      oe_n_nxt   = 1'b1;
    end else if (rise) begin
      if (pin_r[1]) begin
        rx_on_nxt  = 1'b1;
        rx_cnt_nxt = 6'h00;
        if (pend_r) begin
          tx_sh_nxt  = rsp_word;
          tx_cnt_nxt = TX_BITS - 6'h01;
          sdi_nxt    = 1'b1;
          oe_n_nxt   = 1'b0;
        end
      end else begin
        if (rx_on_r) begin
          rx_sh_nxt  = {rx_sh_r[CMD_W-2:0], pin_r[2]};
          rx_cnt_nxt = rx_cnt_r + 6'h01;
          if (rx_cnt_r == RX_BITS - 6'h01) begin
            rx_on_nxt = 1'b0;
            vld_nxt   = 1'b1;
          end
        end
        if (tx_cnt_r != 6'h00) begin
          sdi_nxt    = tx_sh_r[CMD_W-1];
          tx_sh_nxt  = {tx_sh_r[CMD_W-2:0], 1'b0};
          tx_cnt_nxt = tx_cnt_r - 6'h01;
        end else begin
          sdi_nxt    = 1'b0;
          oe_n_nxt   = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sh_r  <= '0;
      rx_cnt_r <= 6'h00;
      rx_on_r  <= 1'b0;
      vld_r    <= 1'b0;
      tx_sh_r  <= '0;
      tx_cnt_r <= 6'h00;
      pend_r   <= 1'b0;
      sdi_r    <= 1'b0;
      oe_n_r   <= 1'b1;
    end else begin
      rx_sh_r  <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_on_r  <= rx_on_nxt;
      vld_r    <= vld_nxt;
      tx_sh_r  <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      pend_r   <= pend_nxt;
      sdi_r    <= sdi_nxt;
      oe_n_r   <= oe_n_nxt;
    end
  end

  assign cmd_valid = vld_r;
  assign cmd_word  = rx_sh_r;
  assign sdi_o     = sdi_r;
  assign sdi_oe_n  = oe_n_r;
endmodule : hcvr_link_port

`default_nettype wire

/* File: verilog/hcvr_list_rom.sv */
// Fixed connection list table with registered read port
`default_nettype none

module hcvr_list_rom
  import hcvr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        nid,
  input  wire logic [7:0]        offset,
  input  wire logic              spdif2,
  output logic      [CMD_W-1:0]  entries,
  output logic      [6:0]        length
);
  logic [8*LIST_BYTES-1:0] lst;
  logic [CMD_W-1:0]        ent_r, ent_nxt;
  logic [6:0]              len_r, len_nxt;

  // Byte 0 of each constant is list entry 0
  function automatic logic [8*LIST_BYTES-1:0] list_of(
    input logic [7:0] n,
    input logic       sp2
  );
    unique case (n)
      8'h07:                      list_of = 96'h24; // [R9]
      8'h08:                      list_of = 96'h23;
      8'h09:                      list_of = 96'h22;
      8'h0A:                      list_of = 96'h1F;
      8'h0B:                      list_of = 96'h1D1C_1B1A1918; // [R10]
      8'h0C, 8'h0E:               list_of = 96'h0B02; // [R11]
      8'h0D:                      list_of = 96'h0B03;
      8'h14, 8'h15, 8'h18, 8'h19,
      8'h1A, 8'h1B:               list_of = 96'h0D0C; // [R12]
      8'h16:                      list_of = 96'h0E; // [R13]
      8'h1E:                      list_of = 96'h06; // [R14]
      NID_SPDIF_OUT2:             list_of = sp2 ? 96'h06 : 96'h0;
      8'h22, 8'h23, 8'h24:
        list_of = 96'h0B_15141D1C_1B1A1918; // [R15]
      default:                    list_of = 96'h0;
    endcase
  endfunction : list_of

  function automatic logic [6:0] len_of(input logic [8*LIST_BYTES-1:0] l);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < LIST_BYTES; i++) begin
      if (l[8*i +: 8] != 8'h00) begin
        c = 7'(i + 1);
      end
    end
    len_of = c;
  endfunction : len_of

  assign lst = list_of(nid, spdif2);

  always_comb begin
    ent_nxt = '0;
    // Offset selects a block of four; past the table reads zero
    if (offset[7:2] < LIST_BLOCKS) begin // [R8] [R16]
      ent_nxt = lst[{offset[3:2], 5'b00000} +: CMD_W];
    end
    len_nxt = len_of(lst); // [R1]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ent_r <= '0;
      len_r <= 7'h00;
    end else begin
      ent_r <= ent_nxt;
      len_r <= len_nxt;
    end
  end

  assign entries = ent_r;
  assign length  = len_r;
endmodule : hcvr_list_rom

`default_nettype wire

/* File: verilog/hcvr_pkg.sv */
// Constants shared by the codec verb responder and its helpers
`default_nettype none

package hcvr_pkg;
  // Command word layout
  localparam int          CMD_W          = 32;
  localparam int          CAD_LSB        = 28;
  localparam int          NID_LSB        = 20;
  localparam int          VERB12_LSB     = 8;
  localparam int          VERB4_LSB      = 16;
  localparam logic [3:0]  VERB4_LO       = 4'h2;
  localparam logic [3:0]  VERB4_HI       = 4'hD;
  // Verb codes
  localparam logic [11:0] VERB_GET_PARAM = 12'hF00;
  localparam logic [11:0] VERB_SET_SEL   = 12'h701;
  localparam logic [11:0] VERB_GET_LIST  = 12'hF02;
  localparam logic [11:0] VERB_GET_PROC  = 12'hF03;
  localparam logic [11:0] VERB_SET_PROC  = 12'h703;
  localparam logic [3:0]  VERB_GET_COEF  = 4'hD;
  localparam logic [3:0]  VERB_SET_COEF  = 4'h5;
  // Parameter identifiers
  localparam logic [7:0]  PID_LIST_LEN   = 8'h0E;
  localparam logic [7:0]  PID_POWER      = 8'h0F;
  localparam logic [7:0]  PID_PROC       = 8'h10;
  localparam logic [7:0]  PID_GPIO       = 8'h11;
  localparam logic [7:0]  PID_KNOB       = 8'h13;
  // Nodes with special answers
  localparam logic [7:0]  NID_KNOB       = 8'h21;
  localparam logic [7:0]  NID_VENDOR     = 8'h20;
  localparam logic [7:0]  NID_SPDIF_OUT2 = 8'h11;
  // Parameter field positions and fixed values
  localparam int          LEN_FORM_BIT   = 7;
  localparam logic        LEN_FORM_SHORT = 1'b0;
  localparam int          POW_EXTENDED_POWER_STATES_FLAG_BIT   = 31;
  localparam int          POW_STOPPED_LINK_CLOCK_OK_BIT = 30;
  localparam logic [3:0]  POW_D_SUPPORT  = 4'hF;
  localparam int          PROC_NCOEF_LSB = 8;
  localparam int          GPIO_WAKE_BIT  = 31;
  localparam int          GPIO_EVT_BIT   = 30;
  localparam logic        GPIO_WAKE_VAL  = 1'b0;
  localparam logic        GPIO_EVT_VAL   = 1'b1;
  localparam logic [7:0]  GPIO_BIDIR_CNT = 8'h04;
  localparam int          KNOB_DELTA_BIT = 7;
  // Connection list geometry
  localparam int          LIST_BYTES     = 12;
  localparam logic [5:0]  LIST_BLOCKS    = 6'h03;
  // Link framing and reset values
  localparam logic [5:0]  RX_BITS        = 6'h20;
  localparam logic [5:0]  TX_BITS        = 6'h21;
  localparam logic [15:0] COEF_RESET     = 16'h0000;
endpackage : hcvr_pkg

`default_nettype wire

/* File: verilog/hcvr_verb_responder.sv */
// Codec verb decoder and answer builder behind the audio link
// Summary of operation
// R1 - List length parameter: bit 7 form flag, bits 6:0 input count.
// R2 - Power states parameter 0Fh sets bits 3:0; older variant zero above.
// R3 - Low-power variant also sets bits 31 and 30, zero in 29:4.
// R4 - Processing parameter 10h: coefficient count 15:8, linear flag bit 0.
// R5 - GPIO parameter 11h: wake 0, event report 1, bidir count 04h.
// R6 - Knob parameter 13h from node 21h: delta bit 7, steps 6:0.
// R7 - Connection select 701h answers all zero for every node.
// R8 - List verb F02h packs four entries from offset, zero past end.
// R9 - Input converters 07h-0Ah return 24h, 23h, 22h, 1Fh respectively.
// R10 - Mixer 0Bh returns 18h-1Bh, then 1Ch and 1Dh, then zeros.
// R11 - Sum nodes 0Ch-0Eh return their DAC then mixer 0Bh.
// R12 - Analog ports return sum 0Ch then sum 0Dh.
// R13 - Mono output 16h returns 0Eh as single entry.
// R14 - Digital outputs 1Eh and optional 11h return converter 06h.
// R15 - Sums 22h-24h return pins, beep, front, surround, then mixer 0Bh.
// R16 - List request to a node without list answers all zero.
// R17 - Processing state get and set both answer zero.
// R18 - Get coefficient index returns index only on vendor node 20h.
// R19 - Set coefficient index loads the index only on vendor node 20h and answers zero.
// R20 - Host asks list entries only of nodes flagged with a list; the bench asks them of every node 00h-27h.
// R21 - Command: address 31:28, node 27:20, then verb and payload.
// R22 - Upper verb nibble 2h-Dh means 4-bit verb, 16-bit payload.
`default_nettype none

module hcvr_verb_responder
  import hcvr_pkg::*;
#(
  parameter logic [3:0] CODEC_ADDR   = 4'h0,
  parameter bit         LOW_POWER    = 1'b1,
  parameter bit         SECOND_SPDIF = 1'b1,
  parameter int         COEF_COUNT   = 0,
  parameter bit         LINEAR_PROC  = 1'b0,
  parameter bit         KNOB_DELTA   = 1'b0,
  parameter int         KNOB_STEPS   = 0
)(
  input  wire logic REF_CLK,
  input  wire logic RSTN,
  input  wire logic BIT_CLK,
  input  wire logic SYNC,
  input  wire logic SDO,
  input  wire logic LINK_RST_N,
  output logic      SDI_O,
  output logic      SDI_OE_N
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOOK   = 2'b01,
    ST_ANSWER = 2'b11
  } hcvr_state_e;

  if (COEF_COUNT < 0 || COEF_COUNT > 255) begin : g_chk_coef
    $error("COEF_COUNT must fit in eight bits");
  end
  if (KNOB_STEPS < 0 || KNOB_STEPS > 127) begin : g_chk_knob
    $error("KNOB_STEPS must fit in seven bits");
  end

  localparam logic [7:0] COEF_CNT_8  = 8'(COEF_COUNT);
  localparam logic [6:0] KNOB_STEP_7 = 7'(KNOB_STEPS);

  hcvr_state_e      state_r, state_nxt;
  logic [CMD_W-1:0] cmd_r, cmd_nxt;
  logic [CMD_W-1:0] rsp_r, rsp_nxt;
  logic             rsp_vld_r, rsp_vld_nxt;
  logic [15:0]      coef_r, coef_nxt;
  logic             cmd_valid;
  logic [CMD_W-1:0] cmd_word;
  logic             link_rst;
  logic [CMD_W-1:0] list_entries;
  logic [6:0]       list_len;
  logic [7:0]       nid;

  function automatic logic wide_verb(input logic [CMD_W-1:0] c);
    logic [3:0] top;
    top = c[VERB4_LSB +: 4];
    wide_verb = (top >= VERB4_LO) && (top <= VERB4_HI); // [R22]
  endfunction : wide_verb

  function automatic logic is_v12(
    input logic [CMD_W-1:0] c,
    input logic [11:0]      v
  );
    is_v12 = !wide_verb(c) && (c[VERB12_LSB +: 12] == v);
  endfunction : is_v12

  function automatic logic is_v4(
    input logic [CMD_W-1:0] c,
    input logic [3:0]       v
  );
    is_v4 = wide_verb(c) && (c[VERB4_LSB +: 4] == v);
  endfunction : is_v4

  function automatic logic is_par(
    input logic [CMD_W-1:0] c,
    input logic [7:0]       p
  );
    is_par = is_v12(c, VERB_GET_PARAM) && (c[7:0] == p);
  endfunction : is_par

  assign nid = cmd_r[NID_LSB +: 8];

  hcvr_link_port u_link (
    .clk        (REF_CLK),
    .rstn       (RSTN),
    .bclk_pin   (BIT_CLK),
    .sync_pin   (SYNC),
    .sdo_pin    (SDO),
    .lrst_n_pin (LINK_RST_N),
    .rsp_valid  (rsp_vld_r),
    .rsp_word   (rsp_r),
    .cmd_valid  (cmd_valid),
    .cmd_word   (cmd_word),
    .link_rst   (link_rst),
    .sdi_o      (SDI_O),
    .sdi_oe_n   (SDI_OE_N)
  );

  hcvr_list_rom u_rom (
    .clk     (REF_CLK),
    .rstn    (RSTN),
    .nid     (nid),
    .offset  (cmd_r[7:0]),
    .spdif2  (SECOND_SPDIF),
    .entries (list_entries),
    .length  (list_len)
  );

  always_comb begin
    state_nxt   = state_r;
    cmd_nxt     = cmd_r;
    rsp_nxt     = rsp_r;
    rsp_vld_nxt = 1'b0;
    coef_nxt    = coef_r;
    unique case (state_r)
      ST_IDLE: begin
        // Commands for another codec address draw no answer
        if (cmd_valid && cmd_word[CAD_LSB +: 4] == CODEC_ADDR) begin // [R21]
          cmd_nxt   = cmd_word;
          state_nxt = ST_LOOK;
        end
      end
      ST_LOOK: begin
        state_nxt = ST_ANSWER;
      end
      ST_ANSWER: begin
        rsp_nxt     = '0; // [R7] [R17] [R16]
        rsp_vld_nxt = 1'b1;
        state_nxt   = ST_IDLE;
        if (is_par(cmd_r, PID_LIST_LEN)) begin
          rsp_nxt[LEN_FORM_BIT] = LEN_FORM_SHORT; // [R1]
          rsp_nxt[6:0]          = list_len;
        end else if (is_par(cmd_r, PID_POWER)) begin
          rsp_nxt[3:0] = POW_D_SUPPORT; // [R2]
          rsp_nxt[POW_EXTENDED_POWER_STATES_FLAG_BIT]    = LOW_POWER; // [R3]
          rsp_nxt[POW_STOPPED_LINK_CLOCK_OK_BIT] = LOW_POWER;
        end else if (is_par(cmd_r, PID_PROC)) begin
          rsp_nxt[PROC_NCOEF_LSB +: 8] = COEF_CNT_8; // [R4]
          rsp_nxt[0]                   = LINEAR_PROC;
        end else if (is_par(cmd_r, PID_GPIO)) begin
          rsp_nxt[GPIO_WAKE_BIT] = GPIO_WAKE_VAL; // [R5]
          rsp_nxt[GPIO_EVT_BIT]  = GPIO_EVT_VAL;
          rsp_nxt[7:0]           = GPIO_BIDIR_CNT;
        end else if (is_par(cmd_r, PID_KNOB) && nid == NID_KNOB) begin
          rsp_nxt[KNOB_DELTA_BIT] = KNOB_DELTA; // [R6]
          rsp_nxt[6:0]            = KNOB_STEP_7;
        end else if (is_v12(cmd_r, VERB_GET_LIST)) begin
          rsp_nxt = list_entries; // [R8] [R9] [R10] [R11] [R12]
        end else if (is_v4(cmd_r, VERB_GET_COEF) && nid == NID_VENDOR) begin
          rsp_nxt[15:0] = coef_r; // [R18]
        end else if (is_v4(cmd_r, VERB_SET_COEF) && nid == NID_VENDOR) begin
          coef_nxt = cmd_r[15:0]; // [R19]
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Link reset drops any command in flight and the index
    if (link_rst) begin
      state_nxt   = ST_IDLE;
      rsp_vld_nxt = 1'b0;
      coef_nxt    = COEF_RESET;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r   <= ST_IDLE;
      cmd_r     <= '0;
      rsp_r     <= '0;
      rsp_vld_r <= 1'b0;
      coef_r    <= COEF_RESET;
    end else begin
      state_r   <= state_nxt;
      cmd_r     <= cmd_nxt;
      rsp_r     <= rsp_nxt;
      rsp_vld_r <= rsp_vld_nxt;
      coef_r    <= coef_nxt;
    end
  end

  AST_ANSWER_TIME: // [R21]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_r == ST_IDLE && cmd_valid && !link_rst
    && cmd_word[CAD_LSB +: 4] == CODEC_ADDR
    |-> ##3 (rsp_vld_r || $past(link_rst) || $past(link_rst, 2)))
    else $error("answer not produced three cycles after command");

  AST_LIST_LEN: // [R1]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_par(cmd_r, PID_LIST_LEN)
    |-> rsp_r[31:7] == 25'h0 && (nid != 8'h0B || rsp_r[6:0] == 7'h06))
    else $error("list length parameter malformed");

  AST_POWER: // [R2]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_par(cmd_r, PID_POWER)
    |-> rsp_r[3:0] == 4'hF && rsp_r[29:4] == 26'h0)
    else $error("power states low field wrong");

  AST_POWER_EXT: // [R3]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_par(cmd_r, PID_POWER)
    |-> rsp_r[31:30] == {2{LOW_POWER}})
    else $error("extended power flags wrong");

  AST_PROC_CAPS: // [R4]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_par(cmd_r, PID_PROC)
    |-> rsp_r[15:8] == COEF_CNT_8 && rsp_r[31:16] == 16'h0
        && rsp_r[7:1] == 7'h0)
    else $error("processing caps wrong");

  AST_GPIO_CAPS: // [R5]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_par(cmd_r, PID_GPIO) |-> rsp_r == 32'h4000_0004)
    else $error("gpio caps wrong");

  AST_KNOB_NODE: // [R6]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_par(cmd_r, PID_KNOB) && nid != NID_KNOB
    |-> rsp_r == 32'h0)
    else $error("knob caps answered by wrong node");

  AST_ZERO_SETS: // [R7]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && (cmd_r[19:8] == VERB_SET_SEL || is_v12(cmd_r, VERB_GET_PROC)
    || cmd_r[19:8] == VERB_SET_PROC || is_v4(cmd_r, VERB_SET_COEF))
    |-> rsp_r == 32'h0)
    else $error("set or processing verb answered nonzero");

  AST_MIXER_LIST: // [R10]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_v12(cmd_r, VERB_GET_LIST) && nid == 8'h0B
    |-> rsp_r == (cmd_r[7:2] == 6'h0 ? 32'h1B1A_1918 :
                  cmd_r[7:2] == 6'h1 ? 32'h0000_1D1C : 32'h0))
    else $error("mixer list entries wrong");

  AST_ADC_SUM_LIST: // [R15]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_v12(cmd_r, VERB_GET_LIST) && nid == 8'h23
    && cmd_r[7:2] == 6'h2 |-> rsp_r == 32'h0000_000B)
    else $error("sum list third block wrong");

  AST_NO_LIST: // [R16]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_v12(cmd_r, VERB_GET_LIST) && nid == 8'h02
    |-> rsp_r == 32'h0)
    else $error("node without list answered nonzero");

  AST_COEF_ROUND: // [R19]
  assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rsp_vld_r && is_v4(cmd_r, VERB_SET_COEF) && nid == NID_VENDOR
    |-> coef_r == cmd_r[15:0])
    else $error("coefficient index not loaded");
endmodule : hcvr_verb_responder

`default_nettype wire
